// ==== rtl/mode_reg_defs.svh ====
// Field positions, select codes, reset values and timing counts for the mode register block
`ifndef MODE_REG_DEFS_SVH
`define MODE_REG_DEFS_SVH

`define SEL_PRIMARY       2'h0
`define SEL_SECOND        2'h1
`define SEL_THIRD         2'h2
`define SEL_FOURTH        2'h3

`define F_BURST_LSB       0
`define F_CL_LOW_BIT      2
`define F_ORDER_BIT       3
`define F_CL_LSB          4
`define F_TEST_BIT        7
`define F_DLL_RST_BIT     8
`define F_WR_LSB          9
`define F_DLL_KEEP_BIT    12
`define F_CHOP_PIN_BIT    12
`define F_HIGH_LSB        13

`define MODE_WORD_RESET   15'h0000

`define MODE_UPDATE_DELAY_CYC 12
`define MODE_TO_MODE_GAP_CYC  4

`endif

// ==== rtl/mode_reg_pkg.sv ====
// Types shared by the mode register block
package mode_reg_pkg;

  typedef enum logic [1:0] {
    BURST_FIXED8,
    BURST_ON_FLY,
    BURST_FIXED_CHOP,
    BURST_RSVD
  } burst_mode_e;

  typedef enum logic {
    UPD_IDLE,
    UPD_WAIT
  } upd_state_e;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [14:0] addr;
  } ca_bus_s;

  typedef struct packed {
    burst_mode_e burst_mode;
    logic        order_interleave;
    logic [3:0]  cas_latency;
    logic        cl_reserved;
    logic [3:0]  write_recovery;
    logic        wr_reserved;
    logic        powerdown_dll_keep;
    logic        vendor_test_select;
  } mode_fields_s;

  typedef struct packed {
    logic        valid;
    logic        is_read;
    logic        chop;
    logic [23:0] order;
  } burst_info_s;

endpackage

// ==== rtl/burst_order_gen.sv ====
// Word order of one burst from its start column and the burst type
`timescale 1ns/1ns
module burst_order_gen (
  input  logic [2:0]  start_i,
  input  logic        interleave_i,
  output logic [23:0] order_o
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_word
      localparam logic [2:0] IDX = 3'(i);
      // Sequential wraps inside each half; interleaved is a plain xor
      assign order_o[3*i +: 3] = interleave_i ? (start_i ^ IDX) :
                                 {start_i[2] ^ IDX[2], 2'(start_i[1:0] + IDX[1:0])}; // RQ21
    end
  endgenerate
endmodule

// ==== rtl/dram_mode_register_program.sv ====
// Mode register set decode, primary mode register and burst order for the DRAM command bus
//
// What the document requires
// [RQ1] Four mode registers, changed only by mode set
// [RQ2] Controller writes every register after reset
// [RQ3] Each mode set replaces the whole word
// [RQ4] Mode set and DLL reset keep array
// [RQ5] Controller spaces mode sets by mode gap
// [RQ6] Other commands wait the mode update delay
// [RQ7] Mode set only while device idle
// [RQ8] Termination on: ODT low until delay ends
// [RQ9] Termination off: ODT level free
// [RQ10] All command and bank pins low: primary
// [RQ11] Bank pair selects one of four registers
// [RQ12] Top two address bits zero at mode set
// [RQ13] Three bits choose write recovery cycles
// [RQ14] Controller programs recovery no below minimum
// [RQ15] Two bits choose burst length mode
// [RQ16] On the fly: chop pin per command
// [RQ17] One bit chooses sequential or interleaved
// [RQ18] Four bits decode CAS latency
// [RQ19] One bit keeps DLL in powerdown
// [RQ20] Burst order from length, type, start
// [RQ21] Start column and wrap give word order
// [RQ22] Read latency is additive plus CAS
// [RQ23] DLL reset bit clears itself
// [RQ24] Controller keeps vendor test bit zero
// [RQ25] New fields act after update delay
`timescale 1ns/1ns
`include "mode_reg_defs.svh"
module dram_mode_register_program #(
  parameter int unsigned UPDATE_CYC = `MODE_UPDATE_DELAY_CYC,
  parameter int unsigned GAP_CYC    = `MODE_TO_MODE_GAP_CYC,
  parameter int unsigned CW         = 8
) (
  input  logic                       ref_clk_i,
  input  logic                       rst_i,
  input  mode_reg_pkg::ca_bus_s      ca_i,
  input  logic                       cke_i,
  input  logic [3:0]                 additive_latency_i,
  output mode_reg_pkg::mode_fields_s fields_o,
  output logic [4:0]                 read_latency_o,
  output mode_reg_pkg::burst_info_s  burst_o,
  output logic [3:0][14:0]           mode_word_o,
  output logic                       dll_reset_o,
  output logic                       mode_busy_o,
  output logic                       mode_gap_err_o,
  output logic                       early_cmd_err_o,
  output logic                       addr_high_err_o
);
  import mode_reg_pkg::*;

  localparam int UPD_CHK = UPDATE_CYC;

  // Pin synchronisers; the first stage feeds only the second
  ca_bus_s ca_s1_r;
  ca_bus_s ca_s2_r;
  logic    cke_s1_r;
  logic    cke_s2_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ca_s1_r  <= '1;
      ca_s2_r  <= '1;
      cke_s1_r <= 1'b0;
      cke_s2_r <= 1'b0;
    end else begin
      ca_s1_r  <= ca_i;
      ca_s2_r  <= ca_s1_r;
      cke_s1_r <= cke_i;
      cke_s2_r <= cke_s1_r;
    end
  end

  function automatic mode_fields_s decode_fields(input logic [14:0] w);
    mode_fields_s f;
    logic [2:0]   clc;
    f                    = '0;
    clc                  = w[`F_CL_LSB +: 3];
    f.burst_mode         = burst_mode_e'(w[`F_BURST_LSB +: 2]); // RQ15
    f.order_interleave   = w[`F_ORDER_BIT]; // RQ17
    f.powerdown_dll_keep = w[`F_DLL_KEEP_BIT]; // RQ19
    f.vendor_test_select = w[`F_TEST_BIT];
    if (!w[`F_CL_LOW_BIT] && (clc != 3'h0)) begin
      f.cas_latency = 4'h4 + {1'b0, clc}; // RQ18
    end else if (w[`F_CL_LOW_BIT] && (clc < 3'h3)) begin
      f.cas_latency = 4'hc + {1'b0, clc}; // RQ18
    end else begin
      f.cl_reserved = 1'b1; // RQ18
    end
    case (w[`F_WR_LSB +: 3]) // RQ13
      3'h0:    f.write_recovery = 4'h5;
      3'h1:    f.write_recovery = 4'h6;
      3'h2:    f.write_recovery = 4'h7;
      3'h3:    f.write_recovery = 4'h8;
      3'h4:    f.write_recovery = 4'ha;
      3'h5:    f.write_recovery = 4'hc;
      3'h6:    f.write_recovery = 4'he;
      default: f.wr_reserved    = 1'b1;
    endcase
    return f;
  endfunction

  // Command decode on the synchronised pins; nothing is taken while clock enable is low
  logic        cmd_taken;
  logic        is_nop;
  logic        mrs_ok;
  logic        rdwr;
  logic        burst_chop;
  logic [1:0]  sel;
  logic [2:0]  start_col;
  logic [23:0] order_w;

  assign cmd_taken = cke_s2_r & ~ca_s2_r.cs_n;
  assign is_nop    = ca_s2_r.ras_n & ca_s2_r.cas_n & ca_s2_r.we_n;
  assign mrs_ok    = cmd_taken & ~ca_s2_r.ras_n & ~ca_s2_r.cas_n & ~ca_s2_r.we_n
                     & ~ca_s2_r.ba[2]; // RQ10
  assign rdwr      = cmd_taken & ca_s2_r.ras_n & ~ca_s2_r.cas_n;
  assign sel       = ca_s2_r.ba[1:0]; // RQ11

  // Writes start on a half boundary, reads on the addressed word
  always_comb begin
    if (ca_s2_r.we_n) begin
      start_col = ca_s2_r.addr[2:0]; // RQ21
    end else if (burst_chop) begin
      start_col = {ca_s2_r.addr[2], 2'b00};
    end else begin
      start_col = 3'h0;
    end
  end

  assign burst_chop = (fields_o.burst_mode == BURST_FIXED_CHOP) |
                      ((fields_o.burst_mode == BURST_ON_FLY) &
                       ~ca_s2_r.addr[`F_CHOP_PIN_BIT]); // RQ16

  burst_order_gen u_order (
    .start_i      (start_col),
    .interleave_i (fields_o.order_interleave),
    .order_o      (order_w)
  );

  logic [3:0][14:0] regs_r,    regs_nxt;
  logic [14:0]      pending_r, pending_nxt;
  upd_state_e       state_r,   state_nxt;
  logic [CW-1:0]    upd_cnt_r, upd_cnt_nxt;
  logic [CW-1:0]    gap_cnt_r, gap_cnt_nxt;
  mode_fields_s     fields_nxt;
  logic [4:0]       rl_nxt;
  burst_info_s      burst_nxt;
  logic             dll_nxt;
  logic             gap_err_nxt;
  logic             early_nxt;
  logic             high_err_nxt;

  always_comb begin
    regs_nxt     = regs_r;
    pending_nxt  = pending_r;
    state_nxt    = state_r;
    upd_cnt_nxt  = upd_cnt_r;
    fields_nxt   = fields_o;
    dll_nxt      = 1'b0;
    gap_err_nxt  = 1'b0;
    early_nxt    = 1'b0;
    high_err_nxt = 1'b0;
    gap_cnt_nxt  = (gap_cnt_r == CW'(GAP_CYC)) ? gap_cnt_r : gap_cnt_r + 1'b1;
    case (state_r)
      UPD_WAIT: begin
        if (upd_cnt_r == '0) begin
          fields_nxt = decode_fields(pending_r); // RQ25
          state_nxt  = UPD_IDLE;
        end else begin
          upd_cnt_nxt = upd_cnt_r - 1'b1;
        end
        if (cmd_taken && !is_nop && !mrs_ok) begin
          early_nxt = 1'b1; // RQ6
        end
      end
      default: begin
        state_nxt = UPD_IDLE;
      end
    endcase
    // Only registers change here; the array is never touched by a mode set
    if (mrs_ok) begin // RQ4
      regs_nxt[sel] = ca_s2_r.addr; // RQ3
      gap_cnt_nxt   = CW'(1);
      gap_err_nxt   = (gap_cnt_r < CW'(GAP_CYC)); // RQ5
      high_err_nxt  = |ca_s2_r.addr[14:`F_HIGH_LSB]; // RQ12
      state_nxt     = UPD_WAIT; // RQ6
      upd_cnt_nxt   = CW'(UPDATE_CYC - 1);
      if (sel == `SEL_PRIMARY) begin
        regs_nxt[sel][`F_DLL_RST_BIT] = 1'b0; // RQ23
        pending_nxt                   = ca_s2_r.addr;
        dll_nxt                       = ca_s2_r.addr[`F_DLL_RST_BIT]; // RQ23
      end
    end
    rl_nxt            = 5'(additive_latency_i) + 5'(fields_o.cas_latency); // RQ22
    burst_nxt.valid   = rdwr;
    burst_nxt.is_read = ca_s2_r.we_n;
    burst_nxt.chop    = rdwr & burst_chop; // RQ15
    burst_nxt.order   = order_w; // RQ20
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      regs_r          <= {4{`MODE_WORD_RESET}};
      pending_r       <= `MODE_WORD_RESET;
      state_r         <= UPD_IDLE;
      upd_cnt_r       <= '0;
      gap_cnt_r       <= CW'(GAP_CYC);
      fields_o        <= '0;
      read_latency_o  <= 5'h00;
      burst_o         <= '0;
      dll_reset_o     <= 1'b0;
      mode_busy_o     <= 1'b0;
      mode_gap_err_o  <= 1'b0;
      early_cmd_err_o <= 1'b0;
      addr_high_err_o <= 1'b0;
    end else begin
      regs_r          <= regs_nxt; // RQ1
      pending_r       <= pending_nxt;
      state_r         <= state_nxt;
      upd_cnt_r       <= upd_cnt_nxt;
      gap_cnt_r       <= gap_cnt_nxt;
      fields_o        <= fields_nxt;
      read_latency_o  <= rl_nxt;
      burst_o         <= burst_nxt;
      dll_reset_o     <= dll_nxt;
      mode_busy_o     <= (state_nxt == UPD_WAIT);
      mode_gap_err_o  <= gap_err_nxt;
      early_cmd_err_o <= early_nxt;
      addr_high_err_o <= high_err_nxt;
    end
  end

  assign mode_word_o = regs_r;

  // Helper: length of the busy window, restarted by each mode set
  logic [CW-1:0] busy_len_r;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_len_r <= '0;
    end else if (mrs_ok) begin
      busy_len_r <= CW'(1);
    end else if (mode_busy_o) begin
      busy_len_r <= busy_len_r + 1'b1;
    end else begin
      busy_len_r <= '0;
    end
  end

  full_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ3
    mrs_ok |=> (regs_r[$past(sel)][14:9] == $past(ca_s2_r.addr[14:9])) &&
               (regs_r[$past(sel)][7:0] == $past(ca_s2_r.addr[7:0])))
    else $error("mode set did not replace the whole word");

  dll_self_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ23
    (mrs_ok && sel == `SEL_PRIMARY && ca_s2_r.addr[`F_DLL_RST_BIT])
      |=> dll_reset_o && !regs_r[0][`F_DLL_RST_BIT])
    else $error("DLL reset not pulsed or not cleared");

  update_delay_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ25
    $fell(mode_busy_o) |-> ($past(busy_len_r) == CW'(UPD_CHK)))
    else $error("update window has wrong length");

  fields_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ6
    !$fell(mode_busy_o) |-> $stable(fields_o))
    else $error("fields changed outside update expiry");

  // Mode sets two cycles apart must be flagged; valid while GAP_CYC exceeds 2
  gap_check_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ5
    (mrs_ok ##2 mrs_ok) |=> mode_gap_err_o)
    else $error("back to back mode sets not flagged");

  chop_fixed_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ15
    (rdwr && fields_o.burst_mode == BURST_FIXED_CHOP) |=> burst_o.valid && burst_o.chop)
    else $error("fixed chop not applied");

  chop_on_fly_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ16
    (rdwr && fields_o.burst_mode == BURST_ON_FLY)
      |=> burst_o.chop == !$past(ca_s2_r.addr[`F_CHOP_PIN_BIT]))
    else $error("on the fly chop pin ignored");

  first_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ21
    (rdwr && ca_s2_r.we_n) |=> burst_o.order[2:0] == $past(ca_s2_r.addr[2:0]))
    else $error("read burst does not start at column");

  last_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ17
    (rdwr && ca_s2_r.we_n && fields_o.order_interleave)
      |=> burst_o.order[23:21] == ($past(ca_s2_r.addr[2:0]) ^ 3'h7))
    else $error("interleaved order wrong");

  read_latency_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ22
    1'b1 |=> read_latency_o ==
      5'($past(additive_latency_i)) + 5'($past(fields_o.cas_latency)))
    else $error("read latency not additive plus CAS");

  cl_range_a: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RQ18
    ($fell(mode_busy_o) && !fields_o.cl_reserved)
      |-> fields_o.cas_latency inside {[4'h5:4'he]})
    else $error("CAS latency out of range");

endmodule

// ==== testbench/mode_ctrl_model.sv ====
// Controller-side model that drives the DRAM command and address pins
`timescale 1ns/1ns
module mode_ctrl_model (
  input  wire logic             ref_clk_i,
  output mode_reg_pkg::ca_bus_s ca_o,
  output logic                  cke_o
);
  import mode_reg_pkg::*;
  initial begin
    ca_o  = '1;
    cke_o = 1'b0;
  end
  // One command for one cycle; released command pins go high and bank and address pins show inverted values so stale ones never match
  task automatic send(input logic [3:0] cmd, input logic [2:0] ba, input logic [14:0] a);
    @(posedge ref_clk_i);
    ca_o <= '{cmd[3], cmd[2], cmd[1], cmd[0], ba, a};
    @(posedge ref_clk_i);
    ca_o <= '{1'b1, 1'b1, 1'b1, 1'b1, ~ba, ~a};
  endtask
  // Whole word on every mode set, top address bits and vendor test bit held at zero
  // No termination pin is driven, so termination stays off around every mode set
  task automatic mode_set(input logic [1:0] sel, input logic [14:0] w);
    send(4'h0, {1'b0, sel}, {2'h0, w[12:8], 1'b0, w[6:0]});
  endtask
  task automatic set_cke(input logic v);
    @(posedge ref_clk_i);
    cke_o <= v;
  endtask
endmodule

// ==== testbench/dram_mode_register_program_bench.sv ====
// Self-checking bench for the mode register block
`timescale 1ns/1ns
module dram_mode_register_program_bench;
  import mode_reg_pkg::*;
  localparam int UPD = 4;
  localparam int GAP = 3;
  logic             ref_clk_i;
  logic             rst_i;
  ca_bus_s          ca;
  logic             cke;
  logic [3:0]       al;
  mode_fields_s     fields;
  logic [4:0]       rl;
  burst_info_s      burst;
  logic [3:0][14:0] words;
  logic             dll_rst;
  logic             busy;
  logic             gap_err;
  logic             early_err;
  logic             high_err;
  logic [4:0]       cl;
  logic [2:0]       st;
  logic [23:0]      eo;
  logic [14:0]      w;
  logic [3:0]       wrtab [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he, 4'h0};
  int               n_errors;
  int               checks;
  int               n_gap;
  int               n_early;
  int               n_high;
  int               n_dll;

  dram_mode_register_program #(.UPDATE_CYC(UPD), .GAP_CYC(GAP)) i_dram_mode_register_program (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ca_i(ca), .cke_i(cke), .additive_latency_i(al),
    .fields_o(fields), .read_latency_o(rl), .burst_o(burst), .mode_word_o(words),
    .dll_reset_o(dll_rst), .mode_busy_o(busy), .mode_gap_err_o(gap_err),
    .early_cmd_err_o(early_err), .addr_high_err_o(high_err));
  mode_ctrl_model i_mode_ctrl_model (.ref_clk_i(ref_clk_i), .ca_o(ca), .cke_o(cke));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  // Pulses last one cycle, so they are counted rather than sampled at one guessed instant
  always @(posedge ref_clk_i) begin
    if (gap_err === 1'b1) n_gap++;
    if (early_err === 1'b1) n_early++;
    if (high_err === 1'b1) n_high++;
    if (dll_rst === 1'b1) n_dll++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic mset(input logic [1:0] sel, input logic [14:0] w);
    mode_fields_s old;
    old = fields;
    i_mode_ctrl_model.mode_set(sel, w);
    repeat (3) @(posedge ref_clk_i);
    #1;
    check(words[sel], w & ((sel == 2'h0) ? 15'h1e7f : 15'h1f7f), "word");
    check(busy, 1'b1, "busy");
    check(fields, old, "fields early");
    repeat (UPD) @(posedge ref_clk_i);
    #1;
    check(busy, 1'b0, "busy end");
  endtask
  task automatic rd_wr(input logic rd, input logic [2:0] s, input logic bc_n);
    i_mode_ctrl_model.send({3'b010, rd}, 3'h0, {2'h0, bc_n, 9'h0, s});
    // The burst report stands for one cycle only, three edges after the command
    repeat (2) @(posedge ref_clk_i);
    #1;
    check(burst.valid, 1'b1, "valid");
    check(burst.is_read, rd, "direction");
  endtask
  function automatic logic [4:0] exp_cl(input logic [2:0] c, input logic a2);
    if (!a2 && c != 3'h0) return 5'(c) + 5'h4;
    if (a2 && c < 3'h3) return 5'(c) + 5'hc;
    return 5'h10;
  endfunction

  initial begin
    rst_i = 1'b1;
    al    = 4'h0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    #1;
    check({31'h0, |words}, 32'h0, "reset words");
    check(busy, 1'b0, "reset busy");
    i_mode_ctrl_model.set_cke(1'b1);
    repeat (3) @(posedge ref_clk_i);
    for (int i = 0; i < 16; i++) begin
      w = {2'h0, i[3], i[2:0], i[0], 1'b0, i[3:1], i[1], i[0], i[1:0]};
      @(posedge ref_clk_i);
      al <= i[3:0];
      mset(2'h0, w);
      cl = exp_cl(i[3:1], i[0]);
      check(fields.burst_mode, i[1:0], "burst mode");
      check(fields.order_interleave, i[1], "order");
      check(fields.powerdown_dll_keep, i[3], "dll keep");
      check(fields.cl_reserved, cl[4], "cl reserved");
      if (!cl[4]) check(fields.cas_latency, cl[3:0], "cas");
      if (!cl[4]) check(rl, 32'(cl[3:0]) + i, "read latency");
      check(fields.wr_reserved, i[2:0] == 3'h7, "wr reserved");
      if (i[2:0] != 3'h7) check(fields.write_recovery, wrtab[i[2:0]], "wr");
      if (i[1:0] != 2'h3) rd_wr(1'b1, 3'h0, 1'b0);
      if (i[1:0] != 2'h3) check(burst.chop, i[1:0] != 2'h0, "fixed chop");
    end
    for (int k = 0; k < 2; k++) begin
      mset(2'h0, 15'h0011 | 15'(k << 3));
      for (int j = 0; j < 32; j++) begin
        rd_wr(j[4], j[2:0], j[3]);
        check(burst.chop, !j[3], "chop");
        st = j[4] ? j[2:0] : (j[3] ? 3'h0 : {j[2], 2'h0});
        for (int n = 0; n < 8; n++)
          eo[3*n +: 3] = k[0] ? (st ^ 3'(n)) : {st[2] ^ n[2], st[1:0] + n[1:0]};
        check(burst.order, eo, "order");
      end
    end
    for (int s = 1; s < 4; s++) mset(2'(s), 15'h0a5a ^ 15'(s));
    i_mode_ctrl_model.send(4'h0, 3'h5, 15'h0123);
    repeat (6) @(posedge ref_clk_i);
    #1;
    check(words[1], 15'h0a5b, "third bank bit");
    i_mode_ctrl_model.set_cke(1'b0);
    repeat (3) @(posedge ref_clk_i);
    i_mode_ctrl_model.mode_set(2'h1, 15'h0111);
    repeat (6) @(posedge ref_clk_i);
    #1;
    check(words[1], 15'h0a5b, "clock enable low");
    i_mode_ctrl_model.set_cke(1'b1);
    repeat (3) @(posedge ref_clk_i);
    // Two mode sets two cycles apart: both stored, spacing flagged
    i_mode_ctrl_model.mode_set(2'h1, 15'h0222);
    i_mode_ctrl_model.mode_set(2'h1, 15'h0333);
    repeat (UPD + 5) @(posedge ref_clk_i);
    #1;
    check(words[1], 15'h0333, "second word");
    i_mode_ctrl_model.mode_set(2'h0, 15'h0011);
    rd_wr(1'b1, 3'h0, 1'b1);
    repeat (UPD + 2) @(posedge ref_clk_i);
    // Deliberately breaks the controller duties: top address bits and test bit set
    i_mode_ctrl_model.send(4'h0, 3'h0, 15'h6091);
    repeat (UPD + 5) @(posedge ref_clk_i);
    #1;
    check(fields.vendor_test_select, 1'b1, "test bit");
    check(n_gap, 1, "gap pulses");
    check(n_early, 1, "early pulses");
    check(n_high, 1, "high bits pulses");
    check(n_dll, 8, "dll reset pulses");
    results();
  end
  initial begin
    #(50 * 8000);
    n_errors++;
    results();
  end
endmodule
